// File: ibf_fetch.v
// instruction fetch unit: buffer hit, refill control and parcel issue
`timescale 1ns/100ps
`include "ibf_defines.vh"
module ibf_fetch
(
  input  wire         mclk,
  input  wire         rst,
  input  wire         go,
  input  wire         jump,
  input  wire [23:0]  jump_addr,
  input  wire         issue_ack,
  output reg          mem_req,
  output reg  [21:0]  mem_addr,
  input  wire         mem_valid,
  input  wire [255:0] mem_data,
  output reg          out_of_buffer,
  output reg  [1:0]   fill_sel_r,
  output reg  [23:0]  paddr_r,
  output reg  [15:0]  next_parcel_reg,
  output reg  [15:0]  current_parcel_reg,
  output reg  [15:0]  second_parcel,
  output reg          two_parcel,
  output reg          issue_valid
);
  localparam ST_RUN  = 3'b001;
  localparam ST_FILL = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg  [2:0]  st_r;
  reg  [1:0]  grp_r;
  reg  [1:0]  sent_r;
  reg  [1:0]  got_r;
  reg         nvalid_r;
  reg  [23:0] naddr_r;
  wire        hit;
  wire [15:0] parcel;
  wire        parcel_ok;
  wire        fill_start;
  wire        fill_we;
  wire [1:0]  fill_grp;
  wire        hold_pair;

  // -----------------------------
  // length decode
  // -----------------------------
  // instruction length from opcode: top bit set marks a two-parcel form
  function is_long;
    input [15:0] p;
    begin
      is_long = p[15];
    end
  endfunction

  // -----------------------------
  // miss detection and fill steering
  // -----------------------------
  // a jump replaces the address, so a compare against the old one is stale
  assign fill_start = (st_r == ST_RUN) && go && !hit && !issue_valid && !jump;
  assign fill_we    = (st_r != ST_RUN) && mem_valid;
  // groups returned in request order, starting with the group latched at the miss;
  // the parcel address may move on as soon as the first group lands
  assign fill_grp   = grp_r + got_r;
  // a waiting two-parcel instruction keeps its second parcel in the next register
  assign hold_pair  = issue_valid && two_parcel && !issue_ack;

  // -----------------------------
  // buffer bank
  // -----------------------------
  // tags, parcel storage and the hit compare against the program parcel address
  ibf_buffer_bank u_bank
  (
    .mclk       (mclk),
    .rst        (rst),
    .paddr      (paddr_r),
    .fill_start (fill_start),
    .fill_buf   (fill_sel_r),
    .fill_tag   (paddr_r[23:6]),
    .fill_we    (fill_we),
    .fill_grp   (fill_grp),
    .fill_data  (mem_data),
    .hit        (hit),
    .parcel     (parcel),
    .parcel_ok  (parcel_ok)
  );

  // -----------------------------
  // refill controller
  // -----------------------------
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_r          <= ST_RUN;
      fill_sel_r    <= 2'b00;
      out_of_buffer <= 1'b0;
      mem_req       <= 1'b0;
      mem_addr      <= 22'h000000;
      sent_r        <= 2'b00;
      got_r         <= 2'b00;
      grp_r         <= 2'b00;
    end
    else
    begin
      out_of_buffer <= fill_start;
      case (st_r)
        ST_RUN:
          if (fill_start)
          begin
            st_r     <= ST_FILL;
            mem_req  <= 1'b1;
            // groups of four words; bank zero word leads each group
            mem_addr <= {paddr_r[23:6], paddr_r[5:4], 2'b00};
            sent_r   <= 2'b00;
            got_r    <= 2'b00;
            grp_r    <= paddr_r[5:4];
          end
        ST_FILL:
        begin
          if (sent_r == 2'b11)
          begin
            mem_req <= 1'b0;
            st_r    <= ST_WAIT;
          end
          else
          begin
            sent_r   <= sent_r + 2'b01;
            mem_addr <= {mem_addr[21:4], mem_addr[3:2] + 2'b01, 2'b00};
          end
          if (mem_valid)
            got_r <= got_r + 2'b01;
        end
        ST_WAIT:
          if (mem_valid)
          begin
            got_r <= got_r + 2'b01;
            if (got_r == 2'b11)
            begin
              st_r       <= ST_RUN;
              fill_sel_r <= fill_sel_r + 2'b01;
            end
          end
        default:
          st_r <= ST_RUN;
      endcase
    end
  end

  // -----------------------------
  // parcel pipeline: buffer -> next -> current
  // -----------------------------
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      paddr_r            <= 24'h000000;
      naddr_r            <= 24'h000000;
      nvalid_r           <= 1'b0;
      next_parcel_reg    <= 16'h0000;
      current_parcel_reg <= 16'h0000;
      second_parcel      <= 16'h0000;
      two_parcel         <= 1'b0;
      issue_valid        <= 1'b0;
    end
    else if (jump)
    begin
      paddr_r     <= jump_addr;
      nvalid_r    <= 1'b0;
      issue_valid <= 1'b0;
    end
    else
    begin
      if (issue_valid && issue_ack)
        issue_valid <= 1'b0;
      if (go && parcel_ok && !nvalid_r && !hold_pair)
      begin
        next_parcel_reg <= parcel;
        naddr_r         <= paddr_r;
        nvalid_r        <= 1'b1;
        // wraps across word boundary, parcel 3 to next word parcel 0
        paddr_r         <= paddr_r + 24'h000001;
      end
      else if (nvalid_r && (!issue_valid || issue_ack))
      begin
        if (!is_long(next_parcel_reg))
        begin
          current_parcel_reg <= next_parcel_reg;
          two_parcel         <= 1'b0;
          issue_valid        <= 1'b1;
          nvalid_r           <= 1'b0;
        end
        else if (go && parcel_ok && naddr_r + 24'h000001 == paddr_r)
        begin
          // first parcel to current, second held in next at issue
          current_parcel_reg <= next_parcel_reg;
          next_parcel_reg    <= parcel;
          second_parcel      <= parcel;
          two_parcel         <= 1'b1;
          issue_valid        <= 1'b1;
          nvalid_r           <= 1'b0;
          paddr_r            <= paddr_r + 24'h000001;
        end
      end
    end
  end
endmodule

// File: ibf_defines.vh
// constants for the instruction buffer fetch unit
`ifndef IBF_DEFINES_VH
`define IBF_DEFINES_VH
`define IBF_NUM_BUF      4
`define IBF_BUF_PARCELS  64
`define IBF_PARCEL_W     16
`define IBF_TAG_W        18
`define IBF_PADDR_W      24
`define IBF_WADDR_W      22
`define IBF_WORD_W       64
`define IBF_WORDS_PER_CLK 4
`define IBF_WORDS_PER_BUF 16
`define IBF_SEL_W        2
`endif

// File: ibf_buffer_bank.v
// four instruction buffers with tags, valid bits and hit compare
`timescale 1ns/100ps
`include "ibf_defines.vh"
module ibf_buffer_bank
(
  input  wire        mclk,
  input  wire        rst,
  input  wire [23:0] paddr,
  input  wire        fill_start,
  input  wire [1:0]  fill_buf,
  input  wire [17:0] fill_tag,
  input  wire        fill_we,
  input  wire [1:0]  fill_grp,
  input  wire [255:0] fill_data,
  output reg         hit,
  output reg  [15:0] parcel,
  output reg         parcel_ok
);
  reg [15:0] mem [0:255];
  reg [17:0] tag_r [0:3];
  reg [3:0]  tag_v_r;
  reg [3:0]  grp_v_r [0:3];
  integer    i;
  integer    k;
  integer    j;
  reg [1:0]  hb;

  // -----------------------------
  // parallel tag compare and parcel select
  // -----------------------------
  always @*
  begin
    hit = 1'b0;
    hb = 2'b00;
    for (i = 0; i < 4; i = i + 1)
      if (tag_v_r[i] && tag_r[i] == paddr[23:6])
      begin
        hit = 1'b1;
        hb = i[1:0];
      end
    parcel = mem[{hb, paddr[5:0]}];
    parcel_ok = hit && grp_v_r[hb][paddr[5:4]];
  end

  // tag registers, cleared invalid at reset
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tag_v_r <= 4'h0;
      for (k = 0; k < 4; k = k + 1)
      begin
        tag_r[k] <= 18'h00000;
        grp_v_r[k] <= 4'h0;
      end
    end
    else if (fill_start)
    begin
      tag_r[fill_buf] <= fill_tag;
      tag_v_r[fill_buf] <= 1'b1;
      grp_v_r[fill_buf] <= 4'h0;
    end
    else if (fill_we)
      grp_v_r[fill_buf][fill_grp] <= 1'b1;
  end

  // parcel storage: four words (16 parcels) written per clock
  always @(posedge mclk)
  begin
    if (fill_we)
      for (j = 0; j < 16; j = j + 1)
        mem[{fill_buf, fill_grp, j[3:0]}] <= fill_data[255 - 16*j -: 16];
  end
endmodule

// File: ibf_fetch_properties.sv
// checker for the instruction buffer fetch unit
`timescale 1ns/100ps
// ----------
// checker
// ----------
module ibf_fetch_chk
(
  input wire        mclk,
  input wire        rst,
  input wire        issue_ack,
  input wire        mem_req,
  input wire [21:0] mem_addr,
  input wire        out_of_buffer,
  input wire [1:0]  fill_sel_r,
  input wire [23:0] paddr_r,
  input wire [15:0] next_parcel_reg,
  input wire [15:0] current_parcel_reg,
  input wire [15:0] second_parcel,
  input wire        two_parcel,
  input wire        issue_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  oob_pulse_a: assert property (out_of_buffer |-> mem_req ##1 !out_of_buffer)
    else $error("miss flag not a one-cycle pulse with a request");
  req_four_a: assert property ($rose(mem_req) |-> mem_req[*4] ##1 !mem_req)
    else $error("memory request not four cycles long");
  first_grp_a: assert property ($rose(mem_req) |-> mem_addr[21:2] == paddr_r[23:4])
    else $error("first group misses the addressed parcel");
  bank_zero_a: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("group not aligned to bank zero");
  sel_step_a: assert property ($changed(fill_sel_r) |-> fill_sel_r == $past(fill_sel_r) + 2'h1)
    else $error("refill select did not step by one");
  issue_stall_a: assert property (mem_req |-> !issue_valid)
    else $error("issue during refill");
  cur_from_next_a: assert property ($rose(issue_valid) |-> current_parcel_reg == $past(next_parcel_reg))
    else $error("current parcel not taken from next parcel");
  issue_hold_a: assert property (issue_valid && !issue_ack |=> issue_valid && $stable(current_parcel_reg))
    else $error("issued parcel dropped before acknowledge");
  pair_len_a: assert property (issue_valid |-> two_parcel == current_parcel_reg[15])
    else $error("instruction length wrong");
  pair_next_a: assert property (issue_valid && two_parcel |-> second_parcel == next_parcel_reg)
    else $error("second parcel not in next parcel register");
endmodule
bind ibf_fetch ibf_fetch_chk i_chk (.mclk, .rst, .issue_ack, .mem_req, .mem_addr, .out_of_buffer, .fill_sel_r,
  .paddr_r, .next_parcel_reg, .current_parcel_reg, .second_parcel, .two_parcel, .issue_valid);

// File: ibf_mem_model.sv
// banked memory model answering four words a clock
`timescale 1ns/100ps
module ibf_mem_model
(
  input  wire         mclk,
  input  wire         slow,
  input  wire         mem_req,
  input  wire [21:0]  mem_addr,
  output wire         mem_valid,
  output wire [255:0] mem_data
);
  reg         req_d = 1'b0;
  reg         req_q = 1'b0;
  reg [255:0] dat_d = 256'h0;
  reg [255:0] dat_q = 256'h0;
  integer     i;
  // each parcel holds the low 16 bits of its own address; idle data is inverted
  always @(posedge mclk)
  begin
    req_d <= mem_req;
    req_q <= req_d;
    dat_q <= req_d ? dat_d : ~dat_q;
    for (i = 0; i < 16; i = i + 1)
      dat_d[255-16*i -: 16] <= mem_req ? {mem_addr[13:0], 2'h0} + i[15:0] : ~dat_d[255-16*i -: 16];
  end
  // slow mode adds one cycle of latency
  assign mem_valid = slow ? req_q : req_d;
  assign mem_data  = slow ? dat_q : dat_d;
endmodule

// File: ibf_fetch_tb_top.sv
// testbench for the instruction buffer fetch unit
`timescale 1ns/100ps
module ibf_fetch_tb_top;
  reg          mclk = 1'b0;
  reg          rst = 1'b1;
  reg          go = 1'b0;
  reg          jump = 1'b0;
  reg  [23:0]  jump_addr = 24'h0;
  reg          issue_ack = 1'b0;
  reg          slow = 1'b0;
  wire         mem_req, mem_valid, out_of_buffer, two_parcel, issue_valid;
  wire [21:0]  mem_addr;
  wire [255:0] mem_data;
  wire [1:0]   fill_sel_r;
  wire [23:0]  paddr_r;
  wire [15:0]  next_parcel_reg, current_parcel_reg, second_parcel;
  integer      mismatches = 0;
  integer      tests_run = 0;
  integer      cycles = 0;
  integer      misses = 0;
  integer      k;
  ibf_fetch i_dut (.mclk, .rst, .go, .jump, .jump_addr, .issue_ack, .mem_req, .mem_addr, .mem_valid, .mem_data,
    .out_of_buffer, .fill_sel_r, .paddr_r, .next_parcel_reg, .current_parcel_reg, .second_parcel, .two_parcel,
    .issue_valid);
  ibf_mem_model i_mem (.mclk, .slow, .mem_req, .mem_addr, .mem_valid, .mem_data);
  initial forever #50 mclk = ~mclk;
  // cycle count, miss count and hang limit
  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (out_of_buffer === 1'b1) misses = misses + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      close_out;
    end
  end
  task check(input [47:0] what, input [23:0] exp, input [23:0] got);
    begin
      tests_run = tests_run + 1;
      if (exp !== got)
      begin
        mismatches = mismatches + 1;
        $display("unexpected %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // jump to an address, wait for issue, judge parcel, length and refill count
  task fetch(input [23:0] a, input [1:0] miss);
    integer   n, m0;
    reg [1:0] s0;
    reg [1:0] s1;
    begin
      @(posedge mclk);
      m0 = misses;
      s0 = fill_sel_r;
      s1 = s0 + miss;
      go <= 1'b1;
      jump <= 1'b1;
      jump_addr <= a;
      @(posedge mclk);
      jump <= 1'b0;
      n = 0;
      #1;
      while (issue_valid !== 1'b1 && n < 60)
      begin
        @(posedge mclk);
        #1;
        n = n + 1;
      end
      check("issue", 1'b1, issue_valid);
      check("parcel", a[15:0], current_parcel_reg);
      check("pair", a[15], two_parcel);
      if (a[15]) check("second", a[15:0] + 16'h1, second_parcel);
      check("misses", miss, misses - m0);
      @(posedge mclk);
      issue_ack <= 1'b1;
      go <= 1'b0;
      // second ack drains a parcel prefetched while the first one waited
      repeat (2) @(posedge mclk);
      issue_ack <= 1'b0;
      #1;
      check("select", s1, fill_sel_r);
    end
  endtask
  // hold reset and look at the cleared state
  task t_reset;
    begin
      @(posedge mclk);
      rst <= 1'b1;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      check("sel", 2'h0, fill_sel_r);
      check("issue", 1'b0, issue_valid);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial
  begin
    t_reset;
    fetch(24'h001234, 2'h1);
    fetch(24'h001235, 2'h0);
    fetch(24'h001200, 2'h0);
    fetch(24'h008003, 2'h1);
    slow <= 1'b1;
    for (k = 1; k < 6; k = k + 1)
      fetch({k[5:0], 18'h00007}, 2'h1);
    slow <= 1'b0;
    t_reset;
    fetch(24'h008003, 2'h1);
    close_out;
  end
endmodule
